// ---- verilog/accel_vector_magnitude_detect.sv ----
// Accelerometer vector magnitude change detector with its register file
// Behaviour
// - Event when distance from reference exceeds threshold longer than debounce.
// - References held inside or from init registers; the held one is never readable, the init registers read back.
// - Unlatched: flag follows condition, set debounced, clear debounced except in clear mode.
// - Latched: flag holds until interrupt source register 0x0C is read.
// - Reference source 0: capture live sample when function is enabled.
// - Reference source 1: initial-reference registers give starting reference.
// - Update bit 0: reference replaced by current sample on each trigger.
// - Update bit 1: reference kept from enable time on trigger.
// - Both bits 1: initial-reference writes act immediately as reference.
// - Runs only while enabled, off by default; loads reference on enabling.
// - Below threshold: counter decrements, or clears when clear mode set.
// - Threshold is 13-bit unsigned at accelerometer output resolution.
// - Counter advances per effective sample; hybrid mode halves the rate.
// - Initial references are signed 14-bit, split into high and low bytes.
`timescale 1ns/100ps
`default_nettype none
`include "vecm_defs.svh"

module accel_vector_magnitude_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Internal register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rdata_valid_ff,
  // Accelerometer samples
  input wire logic sample_valid,
  input wire vecm_pkg::axes_s sample,
  input wire logic hybrid_mode,
  // Event
  output logic event_flag_ff
);

  function automatic vecm_pkg::axis_t set_byte(input vecm_pkg::axis_t old,
                                               input logic hi,
                                               input logic [7:0] d);
    return hi ? {d[5:0], old[7:0]} : {old[13:8], d};
  endfunction

  logic [7:0] cfg_ff;
  logic [7:0] ths_msb_ff;
  logic [7:0] ths_lsb_ff;
  logic [7:0] cnt_ff;
  vecm_pkg::axes_s init_ff;
  vecm_pkg::axes_s ref_ff;
  vecm_pkg::axes_s last_ff;
  logic [7:0] dbc_ff;
  logic en_d_ff;
  logic phase_ff;

  // Register decode
  wire wr_cfg = reg_wr && reg_addr == `VECM_CFG_ADDR;
  wire wr_ths_msb = reg_wr && reg_addr == `VECM_THS_MSB_ADDR;
  wire wr_ths_lsb = reg_wr && reg_addr == `VECM_THS_LSB_ADDR;
  wire wr_cnt = reg_wr && reg_addr == `VECM_CNT_ADDR;
  wire wr_x = reg_wr && (reg_addr == `VECM_INITX_MSB_ADDR ||
                         reg_addr == `VECM_INITX_LSB_ADDR);
  wire wr_y = reg_wr && (reg_addr == `VECM_INITY_MSB_ADDR ||
                         reg_addr == `VECM_INITY_LSB_ADDR);
  wire wr_z = reg_wr && (reg_addr == `VECM_INITZ_MSB_ADDR ||
                         reg_addr == `VECM_INITZ_LSB_ADDR);
  // MSB halves sit on the odd offsets of each axis pair
  wire wr_hi = (reg_addr == `VECM_INITX_MSB_ADDR) ||
               (reg_addr == `VECM_INITY_MSB_ADDR) ||
               (reg_addr == `VECM_INITZ_MSB_ADDR);
  wire rd_src = reg_rd && reg_addr == `VECM_INT_SRC_ADDR;

  // Configuration fields
  wire latch_en = cfg_ff[`VECM_CFG_LATCH_BIT];
  wire ref_init = cfg_ff[`VECM_CFG_REFSRC_BIT];
  wire ref_hold = cfg_ff[`VECM_CFG_REFHOLD_BIT];
  wire en = cfg_ff[`VECM_CFG_EN_BIT];
  wire clr_mode = ths_msb_ff[`VECM_THS_CLRMODE_BIT];
  wire [12:0] ths = {ths_msb_ff[4:0], ths_lsb_ff};

  // Sequencing
  wire en_rise = en && !en_d_ff;
  wire run = en && en_d_ff;
  wire tick = sample_valid && run && (!hybrid_mode || phase_ff);

  // Live init registers replace the stored reference in this mode
  wire vecm_pkg::axes_s act_ref =
      (ref_init && ref_hold) ? init_ff : ref_ff;

  logic [31:0] dist_sq;
  vecm_distance vecm_distance_i (
    .cur(sample),
    .refv(act_ref),
    .dist_sq(dist_sq)
  );

  // Squared threshold keeps the comparison free of a square root
  wire [25:0] ths_sq = 26'(ths * ths);
  wire above = dist_sq > {6'h00, ths_sq};
  wire at_cnt = dbc_ff >= cnt_ff;
  wire trigger = tick && above && at_cnt;

  // Debounce counter
  wire [7:0] dbc_dn = (clr_mode || dbc_ff == 8'h00) ? 8'h00 :
                      8'(dbc_ff - 8'h01);
  wire [7:0] dbc_up = at_cnt ? cnt_ff : 8'(dbc_ff + 8'h01);
  wire [7:0] nxt_dbc = !run ? 8'h00 :
                       !tick ? dbc_ff :
                       above ? dbc_up : dbc_dn;

  // Event flag: a trigger wins over a clearing read
  wire live_clr = !run || (tick && !above && nxt_dbc == 8'h00);
  wire nxt_event = trigger ? 1'b1 :
                   latch_en ? (event_flag_ff && !rd_src) :
                   (event_flag_ff && !live_clr);

  // Reference update
  wire vecm_pkg::axes_s nxt_ref =
      en_rise ? (ref_init ? init_ff : last_ff) :
      (trigger && !ref_hold) ? sample :
      ref_ff;

  // Read mux; the stored reference has no read path
  wire [7:0] rd_mux =
      reg_addr == `VECM_INT_SRC_ADDR ?
        8'(event_flag_ff) << `VECM_SRC_EVENT_BIT :
      reg_addr == `VECM_CFG_ADDR ? cfg_ff :
      reg_addr == `VECM_THS_MSB_ADDR ? ths_msb_ff :
      reg_addr == `VECM_THS_LSB_ADDR ? ths_lsb_ff :
      reg_addr == `VECM_CNT_ADDR ? cnt_ff :
      reg_addr == `VECM_INITX_MSB_ADDR ? {2'b00, init_ff.x[13:8]} :
      reg_addr == `VECM_INITX_LSB_ADDR ? init_ff.x[7:0] :
      reg_addr == `VECM_INITY_MSB_ADDR ? {2'b00, init_ff.y[13:8]} :
      reg_addr == `VECM_INITY_LSB_ADDR ? init_ff.y[7:0] :
      reg_addr == `VECM_INITZ_MSB_ADDR ? {2'b00, init_ff.z[13:8]} :
      reg_addr == `VECM_INITZ_LSB_ADDR ? init_ff.z[7:0] :
      8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= `VECM_CFG_RESET;
      ths_msb_ff <= `VECM_BYTE_RESET;
      ths_lsb_ff <= `VECM_BYTE_RESET;
      cnt_ff <= `VECM_BYTE_RESET;
    end else begin
      if (wr_cfg) cfg_ff <= reg_wdata & `VECM_CFG_MASK;
      if (wr_ths_msb)
        ths_msb_ff <= reg_wdata & (`VECM_THS_MSB_MASK |
                                   (8'h01 << `VECM_THS_CLRMODE_BIT));
      if (wr_ths_lsb) ths_lsb_ff <= reg_wdata;
      if (wr_cnt) cnt_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      init_ff <= {3{`VECM_AXIS_RESET}};
    end else begin
      if (wr_x) init_ff.x <= set_byte(init_ff.x, wr_hi, reg_wdata);
      if (wr_y) init_ff.y <= set_byte(init_ff.y, wr_hi, reg_wdata);
      if (wr_z) init_ff.z <= set_byte(init_ff.z, wr_hi, reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_ff <= {3{`VECM_AXIS_RESET}};
      last_ff <= {3{`VECM_AXIS_RESET}};
      dbc_ff <= 8'h00;
      en_d_ff <= 1'b0;
      phase_ff <= 1'b0;
      event_flag_ff <= 1'b0;
    end else begin
      ref_ff <= nxt_ref;
      if (sample_valid) last_ff <= sample;
      dbc_ff <= nxt_dbc;
      en_d_ff <= en;
      if (!hybrid_mode) phase_ff <= 1'b0;
      else if (sample_valid) phase_ff <= !phase_ff;
      event_flag_ff <= nxt_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
      reg_rdata_valid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      reg_rdata_valid_ff <= reg_rd;
    end
  end

  // Checks
  a_cfg_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (cfg_ff & ~`VECM_CFG_MASK) == 8'h00)
    else $error("reserved config bits not zero");
  a_trigger_sets_flag: assert property (@(posedge clk) disable iff (rst)
    trigger |=> event_flag_ff)
    else $error("trigger did not raise event flag");
  a_off_clears_count: assert property (@(posedge clk) disable iff (rst)
    !en |=> dbc_ff == 8'h00 && !en_d_ff)
    else $error("debounce counter ran while disabled");
  a_live_flag_clear: assert property (@(posedge clk) disable iff (rst)
    (!latch_en && tick && !above && clr_mode) |=> !event_flag_ff)
    else $error("unlatched flag not cleared");
  a_latch_holds: assert property (@(posedge clk) disable iff (rst)
    (latch_en && event_flag_ff && !rd_src) |=> event_flag_ff)
    else $error("latched flag dropped without source read");
  a_src_read_clear: assert property (@(posedge clk) disable iff (rst)
    (latch_en && rd_src && !trigger) |=> !event_flag_ff)
    else $error("source read did not clear latched flag");
  a_enable_live_ref: assert property (@(posedge clk) disable iff (rst)
    (en_rise && !ref_init) |=> ref_ff == $past(last_ff))
    else $error("live reference not captured on enable");
  a_enable_init_ref: assert property (@(posedge clk) disable iff (rst)
    (en_rise && ref_init) |=> ref_ff == $past(init_ff))
    else $error("init reference not loaded on enable");
  a_trigger_update: assert property (@(posedge clk) disable iff (rst)
    (trigger && !ref_hold) |=> ref_ff == $past(sample))
    else $error("reference not updated on trigger");
  a_trigger_keep: assert property (@(posedge clk) disable iff (rst)
    (trigger && ref_hold) |=> $stable(ref_ff))
    else $error("reference changed on trigger");
  a_live_init_ref: assert property (@(posedge clk) disable iff (rst)
    (ref_init && ref_hold && wr_x && !wr_hi) ##1 (ref_init && ref_hold) |->
      act_ref.x[7:0] == $past(reg_wdata))
    else $error("init write not active at once");
  a_count_decrement: assert property (@(posedge clk) disable iff (rst)
    (tick && !above && !clr_mode && dbc_ff != 8'h00) |=>
      dbc_ff == 8'($past(dbc_ff) - 8'h01))
    else $error("debounce counter did not decrement");
  a_hybrid_skip: assert property (@(posedge clk) disable iff (rst)
    (hybrid_mode && sample_valid && run && !phase_ff) |=> $stable(dbc_ff))
    else $error("counter advanced on skipped hybrid sample");

  c_trigger: cover property (@(posedge clk) disable iff (rst) trigger);
  c_latched_read: cover property (@(posedge clk) disable iff (rst)
    latch_en && event_flag_ff && rd_src);
  c_hybrid_tick: cover property (@(posedge clk) disable iff (rst)
    hybrid_mode && tick);
  c_live_init: cover property (@(posedge clk) disable iff (rst)
    ref_init && ref_hold && trigger);

endmodule

`default_nettype wire

// ---- shared/vecm_defs.svh ----
// Register offsets, field positions and reset values of the vector magnitude block
`ifndef VECM_DEFS_SVH
`define VECM_DEFS_SVH

`define VECM_INT_SRC_ADDR 8'h0C
`define VECM_CFG_ADDR 8'h5F
`define VECM_THS_MSB_ADDR 8'h60
`define VECM_THS_LSB_ADDR 8'h61
`define VECM_CNT_ADDR 8'h62
`define VECM_INITX_MSB_ADDR 8'h63
`define VECM_INITX_LSB_ADDR 8'h64
`define VECM_INITY_MSB_ADDR 8'h65
`define VECM_INITY_LSB_ADDR 8'h66
`define VECM_INITZ_MSB_ADDR 8'h67
`define VECM_INITZ_LSB_ADDR 8'h68

`define VECM_CFG_LATCH_BIT 6
`define VECM_CFG_REFSRC_BIT 5
`define VECM_CFG_REFHOLD_BIT 4
`define VECM_CFG_EN_BIT 3
`define VECM_CFG_MASK 8'h78
`define VECM_THS_CLRMODE_BIT 7
`define VECM_THS_MSB_MASK 8'h1F
`define VECM_INIT_MSB_MASK 8'h3F
`define VECM_SRC_EVENT_BIT 1

`define VECM_CFG_RESET 8'h00
`define VECM_BYTE_RESET 8'h00
`define VECM_AXIS_RESET 14'h0000

`endif

// ---- shared/vecm_pkg.sv ----
// Types shared by the vector magnitude block
package vecm_pkg;

  typedef logic signed [13:0] axis_t;

  typedef struct packed {
    axis_t x;
    axis_t y;
    axis_t z;
  } axes_s;

endpackage

// ---- verilog/vecm_distance.sv ----
// Squared distance between the current sample and the reference vector
`timescale 1ns/100ps
`default_nettype none

module vecm_distance (
  // Vectors
  input wire vecm_pkg::axes_s cur,
  input wire vecm_pkg::axes_s refv,
  // Result
  output logic [31:0] dist_sq
);

  function automatic logic [29:0] sq_diff(input logic signed [13:0] a,
                                          input logic signed [13:0] b);
    logic signed [14:0] d;
    logic [14:0] m;
    d = 15'(a) - 15'(b);
    m = d[14] ? 15'(-d) : 15'(d);
    return 30'(m * m);
  endfunction

  // Square root avoided: comparing squares keeps the threshold exact
  assign dist_sq = 32'(sq_diff(cur.x, refv.x)) + 32'(sq_diff(cur.y, refv.y))
                 + 32'(sq_diff(cur.z, refv.z));

endmodule

`default_nettype wire

// ---- test/accel_vector_magnitude_detect_tb_top.sv ----
// Register-level and sample-stream bench for the vector magnitude detector
`timescale 1ns/100ps
`default_nettype none
`include "vecm_defs.svh"

module accel_vector_magnitude_detect_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_ff;
  logic reg_rdata_valid_ff;
  logic sample_valid = 1'b0;
  vecm_pkg::axes_s sample = '0;
  logic hybrid_mode = 1'b0;
  logic event_flag_ff;
  int err_total = 0;
  int samples_checked = 0;

  accel_vector_magnitude_detect accel_vector_magnitude_detect_i (
    .clk(clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff),
    .reg_rdata_valid_ff(reg_rdata_valid_ff),
    .sample_valid(sample_valid),
    .sample(sample),
    .hybrid_mode(hybrid_mode),
    .event_flag_ff(event_flag_ff)
  );

  always #12.5 clk = ~clk;

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // Read data stands for one cycle only, so it is sampled right after it lands
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge clk);
    reg_rd = 1'b0;
    check("read valid", {7'h00, reg_rdata_valid_ff}, 8'h01);
    check("read data", reg_rdata_ff, exp);
  endtask

  // One sample on the x axis; returns once the flag reflects it
  // Samples stay sparse, standing for a data rate the function supports
  task automatic send(input logic [13:0] xv);
    @(negedge clk);
    sample_valid = 1'b1;
    sample = '0;
    sample.x = xv;
    @(negedge clk);
    sample_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic flag(input logic exp);
    check("event flag", {7'h00, event_flag_ff}, {7'h00, exp});
  endtask

  initial begin
    #(25 * 100000);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd(`VECM_CFG_ADDR, 8'h00);
    rd(`VECM_THS_MSB_ADDR, 8'h00);
    rd(`VECM_CNT_ADDR, 8'h00);
    rd(`VECM_INT_SRC_ADDR, 8'h00);
    flag(1'b0);
    wr(`VECM_CFG_ADDR, 8'hFF);
    rd(`VECM_CFG_ADDR, 8'h78);
    wr(`VECM_CFG_ADDR, 8'h00);
    wr(8'h70, 8'hA5);
    rd(8'h70, 8'h00);
    wr(`VECM_THS_MSB_ADDR, 8'hFF);
    rd(`VECM_THS_MSB_ADDR, 8'h9F);
    wr(`VECM_INITX_MSB_ADDR, 8'hFF);
    rd(`VECM_INITX_MSB_ADDR, 8'h3F);
    wr(`VECM_INITX_MSB_ADDR, 8'h00);
    // Threshold 256, decrement mode, no debounce
    wr(`VECM_THS_MSB_ADDR, 8'h01);
    wr(`VECM_THS_LSB_ADDR, 8'h00);
    wr(`VECM_CNT_ADDR, 8'h00);
    // Hybrid mode: first sample after reset is skipped
    hybrid_mode = 1'b1;
    wr(`VECM_CFG_ADDR, 8'h38);
    send(14'h012C);
    flag(1'b0);
    send(14'h012C);
    flag(1'b1);
    wr(`VECM_CFG_ADDR, 8'h00);
    // The flag drops one edge after the disabling write lands
    @(negedge clk);
    flag(1'b0);
    hybrid_mode = 1'b0;
    // Debounce of two on the fixed init reference
    wr(`VECM_CNT_ADDR, 8'h02);
    wr(`VECM_CFG_ADDR, 8'h38);
    repeat (3) send(14'h0100);
    flag(1'b0);
    repeat (2) send(14'h0101);
    flag(1'b0);
    send(14'h0101);
    flag(1'b1);
    send(14'h0000);
    flag(1'b1);
    send(14'h0000);
    flag(1'b0);
    // Live rewrite of the reference makes 0x12C a zero distance
    wr(`VECM_INITX_MSB_ADDR, 8'h01);
    wr(`VECM_INITX_LSB_ADDR, 8'h2C);
    repeat (3) send(14'h012C);
    flag(1'b0);
    // Latched flag survives a below-threshold sample until source read
    wr(`VECM_CFG_ADDR, 8'h00);
    wr(`VECM_CNT_ADDR, 8'h00);
    wr(`VECM_CFG_ADDR, 8'h78);
    send(14'h0000);
    flag(1'b1);
    send(14'h012C);
    flag(1'b1);
    rd(`VECM_INT_SRC_ADDR, 8'h02);
    @(negedge clk);
    flag(1'b0);
    // Live-sample reference, updated on each trigger, clear mode
    wr(`VECM_CFG_ADDR, 8'h00);
    send(14'h03E8);
    flag(1'b0);
    wr(`VECM_THS_MSB_ADDR, 8'h81);
    wr(`VECM_CFG_ADDR, 8'h08);
    send(14'h03E8);
    flag(1'b0);
    send(14'h07D0);
    flag(1'b1);
    send(14'h07D0);
    flag(1'b0);
    // Reference kept from enable time
    wr(`VECM_CFG_ADDR, 8'h00);
    send(14'h0000);
    wr(`VECM_CFG_ADDR, 8'h18);
    send(14'h01F4);
    flag(1'b1);
    send(14'h01F4);
    flag(1'b1);
    wr(`VECM_CFG_ADDR, 8'h00);
    @(negedge clk);
    flag(1'b0);
    // Each initial-reference byte lands alone in its own half
    wr(`VECM_INITY_LSB_ADDR, 8'h5A);
    rd(`VECM_INITY_LSB_ADDR, 8'h5A);
    rd(`VECM_INITY_MSB_ADDR, 8'h00);
    wr(`VECM_INITZ_MSB_ADDR, 8'hC1);
    rd(`VECM_INITZ_MSB_ADDR, 8'h01);
    rd(`VECM_INITZ_LSB_ADDR, 8'h00);
    rd(`VECM_INITX_LSB_ADDR, 8'h2C);
    rd(`VECM_THS_LSB_ADDR, 8'h00);
    finish_test();
  end
endmodule

`default_nettype wire
